/* File: hw/sscp_port.sv */
// Control port logic: sweep and sequence commands, step code, GPIO.
// Assumes the sweep/sequence engines consume one-cycle command pulses.
`timescale 1ns/1ns

// Operation
// - Sweep mode: start falling edge restarts sweep from beginning.
// - Start pin is ORed with the external trigger.
// - Sweep mode: stop falling edge stops the sweep.
// - Sweep mode: hold falling edge while running freezes the sweep.
// - Sweep mode: hold falling edge while held resumes the sweep.
// - Sequence mode accepts start/branch, stop, hold/resume, event inputs.
// - Start pin acts as sequence start or state branch, not both.
// - As start, falling edge starts sequence at first step.
// - As state branch, low at step end jumps to destination.
// - Sequence mode: stop falling edge stops the sequence.
// - Sequence mode: hold falling edge pauses the sequence.
// - While paused, a rising hold edge resumes the sequence.
// - Event falling edge jumps at once to the step destination.
// - Step code of the current step drives the four outputs.
// - Step code bit 0 is LSB, bit 3 is MSB.
// - GPIO mode: inputs readable, outputs writable by remote control.
// - External trigger has selectable active polarity.
module sscp_port (
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  wire logic                        clkEn,
   input  wire logic [1:0]                  funcSel,
   input  wire logic                        ctrlInEnable,
   input  wire logic                        startAsBranch,
   input  wire logic                        trigActiveHigh,
   input  wire logic                        extTrig,
   input  wire logic [sscp_pkg::IN_W-1:0]   ctrlIn_n,
   input  wire logic                        stepEnd,
   input  wire logic [sscp_pkg::STEP_W-1:0] curStep,
   input  wire logic [sscp_pkg::CODE_W-1:0] curStepCode,
   input  wire logic [sscp_pkg::STEP_W-1:0] curStepDest,
   input  wire logic [sscp_pkg::CODE_W-1:0] gpOutWrite,
   input  wire logic                        gpOutWriteStb,
   output logic      [sscp_pkg::IN_W-1:0]   gpInRead,
   output logic      [sscp_pkg::CODE_W-1:0] stepCodeOut,
   output logic                             sweepStart,
   output logic                             sweepStop,
   output logic                             sweepHold,
   output logic                             sweepResume,
   output logic                             seqStart,
   output logic                             seqStop,
   output logic                             seqHold,
   output logic                             seqResume,
   output logic                             seqJump,
   output logic      [sscp_pkg::STEP_W-1:0] seqJumpStep,
   output logic      [1:0]                  runState
);
   typedef struct packed {
      sscp_pkg::sscp_run_t           run;
      logic                          trigPrev;
      logic [sscp_pkg::CODE_W-1:0]   code;
      logic [sscp_pkg::CODE_W-1:0]   gpOut;
      logic [sscp_pkg::IN_W-1:0]     gpIn;
      logic [sscp_pkg::STEP_W-1:0]   jumpStep;
      logic [8:0]                    pulses;
   } sscp_st_t;

   sscp_st_t st_ff;
   sscp_st_t nxt_st;

   logic [sscp_pkg::IN_W-1:0] lvl;
   logic [sscp_pkg::IN_W-1:0] fall;
   logic [sscp_pkg::IN_W-1:0] rise;

   sscp_edge_det u_edge (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .clkEn     (clkEn),
      .pinIn     (ctrlIn_n),
      .level     (lvl),
      .fallPulse (fall),
      .risePulse (rise)
   );

   logic trigActive;
   logic trigEdge;
   logic isSweep;
   logic isSeq;
   logic startFall;
   logic stopFall;
   logic holdFall;
   logic holdRise;
   logic evtFall;

   assign trigActive = trigActiveHigh ? extTrig : ~extTrig;

   always_comb begin
      isSweep   = (funcSel == 2'(sscp_pkg::SSCP_FUNC_SWEEP));
      isSeq     = (funcSel == 2'(sscp_pkg::SSCP_FUNC_SEQ));
      trigEdge  = clkEn & trigActive & ~st_ff.trigPrev;
      startFall = ctrlInEnable & fall[sscp_pkg::BIT_STRT];
      stopFall  = ctrlInEnable & fall[sscp_pkg::BIT_STOP];
      holdFall  = ctrlInEnable & fall[sscp_pkg::BIT_HOLD];
      holdRise  = ctrlInEnable & rise[sscp_pkg::BIT_HOLD];
      evtFall   = ctrlInEnable & fall[sscp_pkg::BIT_EVT];
   end

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.pulses   = '0;
      nxt_st.trigPrev = trigActive;
      nxt_st.gpIn     = lvl;
      if (gpOutWriteStb) begin
         nxt_st.gpOut = gpOutWrite;
      end
      if (isSweep) begin
         if (startFall | trigEdge) begin
            nxt_st.pulses[0] = 1'b1;
            nxt_st.run       = sscp_pkg::SSCP_RUN;
         end else if (stopFall) begin
            nxt_st.pulses[1] = 1'b1;
            nxt_st.run       = sscp_pkg::SSCP_IDLE;
         end else if (holdFall) begin
            unique case (st_ff.run)
               sscp_pkg::SSCP_RUN: begin
                  nxt_st.pulses[2] = 1'b1;
                  nxt_st.run       = sscp_pkg::SSCP_HOLD;
               end
               sscp_pkg::SSCP_HOLD: begin
                  nxt_st.pulses[3] = 1'b1;
                  nxt_st.run       = sscp_pkg::SSCP_RUN;
               end
               default: ;
            endcase
         end
         nxt_st.code = sscp_pkg::CODE_RST;
      end else if (isSeq) begin
         if ((startFall & ~startAsBranch) | trigEdge) begin
            nxt_st.pulses[4] = 1'b1;
            nxt_st.jumpStep  = sscp_pkg::STEP_FIRST;
            nxt_st.run       = sscp_pkg::SSCP_RUN;
         end else if (stopFall) begin
            nxt_st.pulses[5] = 1'b1;
            nxt_st.run       = sscp_pkg::SSCP_IDLE;
         end else if (holdFall && st_ff.run == sscp_pkg::SSCP_RUN) begin
            nxt_st.pulses[6] = 1'b1;
            nxt_st.run       = sscp_pkg::SSCP_HOLD;
         end else if (holdRise && st_ff.run == sscp_pkg::SSCP_HOLD) begin
            nxt_st.pulses[7] = 1'b1;
            nxt_st.run       = sscp_pkg::SSCP_RUN;
         end else if (evtFall && st_ff.run != sscp_pkg::SSCP_IDLE) begin
            nxt_st.pulses[8] = 1'b1;
            nxt_st.jumpStep  = curStepDest;
         end else if (startAsBranch && ctrlInEnable && stepEnd &&
                      !lvl[sscp_pkg::BIT_STRT] &&
                      st_ff.run == sscp_pkg::SSCP_RUN) begin
            nxt_st.pulses[8] = 1'b1;
            nxt_st.jumpStep  = curStepDest;
         end
         nxt_st.code = (st_ff.run == sscp_pkg::SSCP_IDLE) ?
                       sscp_pkg::CODE_RST : curStepCode;
      end else begin
         nxt_st.run  = sscp_pkg::SSCP_IDLE;
         nxt_st.code = st_ff.gpOut;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_ff <= '{sscp_pkg::SSCP_IDLE, 1'b0, sscp_pkg::CODE_RST,
                    sscp_pkg::CODE_RST, sscp_pkg::IN_IDLE,
                    sscp_pkg::STEP_FIRST, 9'h000};
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   // Pulses last one enabled cycle
   assign sweepStart  = clkEn & st_ff.pulses[0];
   assign sweepStop   = clkEn & st_ff.pulses[1];
   assign sweepHold   = clkEn & st_ff.pulses[2];
   assign sweepResume = clkEn & st_ff.pulses[3];
   assign seqStart    = clkEn & st_ff.pulses[4];
   assign seqStop     = clkEn & st_ff.pulses[5];
   assign seqHold     = clkEn & st_ff.pulses[6];
   assign seqResume   = clkEn & st_ff.pulses[7];
   assign seqJump     = clkEn & st_ff.pulses[8];
   assign seqJumpStep = st_ff.jumpStep;
   assign stepCodeOut = st_ff.code;
   assign gpInRead    = st_ff.gpIn;
   assign runState    = st_ff.run;
endmodule

/* File: hw/sscp_pkg.sv */
// Constants and types for the sweep/sequence control port.
// Assumes one clock domain; all pins are taken as synchronous inputs.
package sscp_pkg;
   localparam int unsigned IN_W    = 4;
   localparam int unsigned CODE_W  = 4;
   localparam int unsigned STEP_W  = 4;
   // Input pin order within the control bus
   localparam int unsigned BIT_EVT  = 0;
   localparam int unsigned BIT_HOLD = 1;
   localparam int unsigned BIT_STOP = 2;
   localparam int unsigned BIT_STRT = 3;
   // Idle level of the active-low pins (pulled up)
   localparam logic [3:0] IN_IDLE   = 4'hF;
   localparam logic [3:0] CODE_RST  = 4'h0;
   localparam logic [3:0] STEP_FIRST = 4'h0;

   typedef enum logic [1:0] {
      SSCP_FUNC_SWEEP,
      SSCP_FUNC_SEQ,
      SSCP_FUNC_GPIO
   } sscp_func_t;

   typedef enum logic [1:0] {
      SSCP_IDLE,
      SSCP_RUN,
      SSCP_HOLD
   } sscp_run_t;
endpackage

/* File: hw/sscp_edge_det.sv */
// Synchroniser and edge detector for the active-low control pins.
// Assumes inputs synchronous to mclk as a baseline; two stages are kept.
`timescale 1ns/1ns
module sscp_edge_det (
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic                      clkEn,
   input  wire logic [sscp_pkg::IN_W-1:0] pinIn,
   output logic      [sscp_pkg::IN_W-1:0] level,
   output logic      [sscp_pkg::IN_W-1:0] fallPulse,
   output logic      [sscp_pkg::IN_W-1:0] risePulse
);
   typedef struct packed {
      logic [sscp_pkg::IN_W-1:0] meta;
      logic [sscp_pkg::IN_W-1:0] sync;
      logic [sscp_pkg::IN_W-1:0] prev;
   } sscp_ed_t;

   sscp_ed_t st_ff;
   sscp_ed_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = pinIn;
      nxt_st.sync = st_ff.meta;
      nxt_st.prev = st_ff.sync;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_ff <= '{sscp_pkg::IN_IDLE, sscp_pkg::IN_IDLE,
                    sscp_pkg::IN_IDLE};
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   genvar i;
   generate
      for (i = 0; i < sscp_pkg::IN_W; i++) begin : g_edge
         assign level[i]     = st_ff.sync[i];
         assign fallPulse[i] = clkEn & st_ff.prev[i] & ~st_ff.sync[i];
         assign risePulse[i] = clkEn & ~st_ff.prev[i] & st_ff.sync[i];
      end
   endgenerate
endmodule

/* File: tb/sscp_port_asserts.sv */
// Concurrent checks on the control port outputs.
// Bound to sscp_port; sees its ports only.
`timescale 1ns/1ns
module sscp_port_asserts (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic [1:0] funcSel,
   input wire logic [3:0] curStepCode,
   input wire logic [3:0] curStepDest,
   input wire logic [3:0] stepCodeOut,
   input wire logic       sweepStop,
   input wire logic       sweepHold,
   input wire logic       sweepResume,
   input wire logic       seqStart,
   input wire logic       seqStop,
   input wire logic       seqHold,
   input wire logic       seqResume,
   input wire logic       seqJump,
   input wire logic [3:0] seqJumpStep,
   input wire logic [1:0] runState
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chk_stop_idle: assert property (
      (sweepStop || seqStop) |-> runState == 2'h0)
      else $error("stop did not idle");
   chk_hold_state: assert property (
      (sweepHold || seqHold) |-> runState == 2'h2)
      else $error("hold did not freeze");
   chk_resume_run: assert property (
      (sweepResume || seqResume) |-> runState == 2'h1)
      else $error("resume did not run");
   chk_start_first: assert property (
      seqStart |-> seqJumpStep == 4'h0 && runState == 2'h1)
      else $error("start not at first step");
   chk_jump_dest: assert property (
      seqJump |-> seqJumpStep == $past(curStepDest))
      else $error("jump step wrong");
   chk_pulse_once: assert property (
      seqJump |=> !seqJump)
      else $error("jump pulse too long");
   chk_code_step: assert property (
      funcSel == 2'h1 && runState == 2'h1 && $past(runState) == 2'h1
      && $stable(curStepCode) |-> stepCodeOut == curStepCode)
      else $error("step code wrong");
   chk_sweep_quiet: assert property (
      funcSel == 2'h0 && $past(funcSel) == 2'h0
      |-> stepCodeOut == 4'h0 && !seqJump)
      else $error("sweep mode not quiet");
   chk_seq_only: assert property (
      funcSel == 2'h1 |-> !(sweepStop || sweepHold || sweepResume))
      else $error("sweep pulse in sequence mode");
endmodule

/* File: tb/sscp_ext_model.sv */
// External controller model driving the control pins and trigger.
// Pins are pulled up, so the idle level is high.
`timescale 1ns/1ns
module sscp_ext_model (
   input  wire logic       mclk,
   output logic      [3:0] pins_n,
   output logic            trig
);
   initial pins_n = 4'hF;
   initial trig = 1'b0;
   task automatic put(input logic [3:0] v, input logic t);
      @(posedge mclk);
      pins_n <= v;
      trig <= t;
   endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for sscp_port.
// Pulse outputs are watched as one vector; one mode per task.
`timescale 1ns/1ns
`define CHK(n,e,g) begin checkCount++; if ((g) !== (e)) begin \
   mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [1:0] funcSel = 2'h0;
   logic       asBr = 1'b0;
   logic       pol = 1'b1;
   logic       stepEnd = 1'b0;
   logic [3:0] code = 4'hA;
   logic [3:0] dest = 4'h9;
   logic [3:0] gpW = 4'h0;
   logic       gpStb = 1'b0;
   logic [3:0] pins_n, gpIn, codeOut, jStep;
   logic       trig;
   logic [1:0] runState;
   logic [8:0] pul;
   int         mismatches = 0;
   int         checkCount = 0;
   always #20 mclk = ~mclk;
   sscp_ext_model u_ext (.mclk(mclk), .pins_n(pins_n), .trig(trig));
   sscp_port u_dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(1'b1),
      .funcSel(funcSel), .ctrlInEnable(1'b1), .startAsBranch(asBr),
      .trigActiveHigh(pol), .extTrig(trig), .ctrlIn_n(pins_n),
      .stepEnd(stepEnd), .curStep(4'h0), .curStepCode(code),
      .curStepDest(dest), .gpOutWrite(gpW), .gpOutWriteStb(gpStb),
      .gpInRead(gpIn), .stepCodeOut(codeOut), .sweepStart(pul[8]),
      .sweepStop(pul[7]), .sweepHold(pul[6]), .sweepResume(pul[5]),
      .seqStart(pul[4]), .seqStop(pul[3]), .seqHold(pul[2]),
      .seqResume(pul[1]), .seqJump(pul[0]), .seqJumpStep(jStep),
      .runState(runState));
   task automatic give_verdict();
      if (mismatches == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Waits up to 8 cycles; index 9 means no pulse expected
   task automatic pulse(input string n, input int i);
      int k;
      k = 0;
      while (pul === 9'h0 && k < 8) begin
         @(negedge mclk);
         k++;
      end
      `CHK(n, 9'h1 << i, pul)
      @(negedge mclk);
   endtask
   task automatic ev(input logic [3:0] v, input logic t, input string n,
                     input int i);
      u_ext.put(v, t);
      pulse(n, i);
   endtask
   task automatic t_sweep();
      ev(4'h7, 1'b0, "swStart", 8);
      `CHK("swCode", 4'h0, codeOut)
      ev(4'hF, 1'b0, "release", 9);
      ev(4'hD, 1'b0, "swHold", 6);
      ev(4'hF, 1'b0, "release", 9);
      ev(4'hD, 1'b0, "swResume", 5);
      ev(4'hE, 1'b0, "evtIgnored", 9);
      ev(4'hB, 1'b0, "swStop", 7);
      `CHK("swIdle", 2'h0, runState)
      ev(4'hF, 1'b1, "trigStart", 8);
      ev(4'hB, 1'b0, "swStop", 7);
   endtask
   task automatic t_seq();
      funcSel <= 2'h1;
      ev(4'h7, 1'b0, "sqStart", 4);
      `CHK("firstStep", 4'h0, jStep)
      `CHK("stepCode", code, codeOut)
      ev(4'hF, 1'b0, "release", 9);
      ev(4'hD, 1'b0, "sqHold", 2);
      `CHK("held", 2'h2, runState)
      ev(4'hF, 1'b0, "sqResume", 1);
      ev(4'hE, 1'b0, "sqJump", 0);
      `CHK("jumpStep", dest, jStep)
      ev(4'hB, 1'b0, "sqStop", 3);
      ev(4'hF, 1'b0, "release", 9);
   endtask
   task automatic t_branch();
      asBr <= 1'b1;
      ev(4'hF, 1'b1, "trigRise", 4);
      // Polarity flips while the trigger is high, so no edge is seen
      pol <= 1'b0;
      ev(4'hF, 1'b0, "trigFall", 4);
      ev(4'hF, 1'b1, "trigWrongEdge", 9);
      ev(4'h7, 1'b1, "noStartAsBranch", 9);
      @(posedge mclk);
      stepEnd <= 1'b1;
      @(posedge mclk);
      stepEnd <= 1'b0;
      pulse("branchJump", 0);
      `CHK("branchStep", dest, jStep)
      ev(4'h3, 1'b1, "sqStop", 3);
   endtask
   task automatic t_gpio();
      funcSel <= 2'h2;
      @(posedge mclk);
      gpW <= 4'h5;
      gpStb <= 1'b1;
      @(posedge mclk);
      gpStb <= 1'b0;
      ev(4'hA, 1'b0, "gpQuiet", 9);
      `CHK("gpOut", 4'h5, codeOut)
      `CHK("gpIn", 4'hA, gpIn)
   endtask
   initial begin
      #(40 * 3000);
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
      t_sweep();
      t_seq();
      t_branch();
      t_gpio();
      give_verdict();
   end
endmodule
bind sscp_port sscp_port_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .funcSel(funcSel), .curStepCode(curStepCode), .curStepDest(curStepDest),
   .stepCodeOut(stepCodeOut), .sweepStop(sweepStop),
   .sweepHold(sweepHold), .sweepResume(sweepResume), .seqStart(seqStart),
   .seqStop(seqStop), .seqHold(seqHold), .seqResume(seqResume),
   .seqJump(seqJump), .seqJumpStep(seqJumpStep), .runState(runState));
